// >>> rtl/serdes_pll_link_ctrl_regs.sv
// Lane PLL control sequencer, status, pre-divide, termination calibration,
// link control and link-parameter checksum registers.
// Assumes the serial configuration port decoder presents byte accesses on cfg_*.
`timescale 1ns/100ps

module serdes_pll_link_ctrl_regs
  import lane_pll_regs_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [11:0] cfg_addr_in,
  input  wire logic [7:0]  cfg_wdata_in,
  input  wire logic        cfg_wr_in,
  input  wire logic        cfg_rd_in,
  input  wire logic        pump_low_edge_in,
  input  wire logic        pump_high_edge_in,
  input  wire logic        loop_lock_in,
  output logic [7:0]       cfg_rdata_out,
  output logic             cfg_rvalid_out,
  output logic             lane_loop_power_on_out,
  output logic             oscillator_cal_run_out,
  output logic [1:0]       refclk_predivide_sel_out,
  output logic             term_cal_start_out,
  output logic             term_cal_busy_out,
  output logic             link_enable_out
);

  logic [7:0]  loop_ctrl_q, predivide_q, term_cal_q, link_a_q, link_b_q;
  logic [7:0]  packed_q [PACKED_COUNT];
  logic [7:0]  sum_q [LANE_COUNT];
  logic [7:0]  sum_d [LANE_COUNT];
  logic        low_s1_q, low_s2_q, high_s1_q, high_s2_q, lock_s1_q, lock_s2_q;
  seq_state_e  state_q, state_d;
  logic [9:0]  cnt_q, cnt_d;
  logic        cal_good_q, cal_good_d;
  logic [7:0]  term_cnt_q;
  logic [7:0]  rdata_q;
  logic        rvalid_q;

  // Decode
  wire wr_loop    = cfg_wr_in && (cfg_addr_in == ADDR_LOOP_CTRL);
  wire wr_prediv  = cfg_wr_in && (cfg_addr_in == ADDR_PREDIVIDE);
  wire wr_term    = cfg_wr_in && (cfg_addr_in == ADDR_TERM_CAL);
  wire wr_link_a  = cfg_wr_in && (cfg_addr_in == ADDR_LINK_CTRL_A);
  wire wr_link_b  = cfg_wr_in && (cfg_addr_in == ADDR_LINK_CTRL_B);
  wire in_packed  = (cfg_addr_in >= ADDR_PACKED_FIRST) && (cfg_addr_in <= ADDR_PACKED_LAST);
  wire [3:0] packed_idx = 4'(cfg_addr_in - ADDR_PACKED_FIRST);

  // Edges from written versus stored value
  wire power_rise = wr_loop && cfg_wdata_in[BIT_POWER_ON] && !loop_ctrl_q[BIT_POWER_ON];
  wire recal_rise = wr_loop && cfg_wdata_in[BIT_RECAL] && !loop_ctrl_q[BIT_RECAL];
  wire power_off  = wr_loop && !cfg_wdata_in[BIT_POWER_ON];
  wire seq_start  = power_rise || (recal_rise && loop_ctrl_q[BIT_POWER_ON]);
  wire term_rise  = wr_term && cfg_wdata_in[BIT_TERM_TRIGGER] && !term_cal_q[BIT_TERM_TRIGGER];

  // Status, all driven by hardware only
  wire locked_w  = lock_s2_q && (state_q == SEQ_DONE);
  wire bias_ok_w = (state_q == SEQ_OSC) || (state_q == SEQ_LOCKW) || (state_q == SEQ_DONE);
  wire osc_run_w = (state_q == SEQ_OSC);
  wire [7:0] status_w = {2'b00, high_s2_q, low_s2_q, cal_good_q, osc_run_w, bias_ok_w, locked_w};

  // Synchronisers for the analog flags
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      {low_s1_q, low_s2_q, high_s1_q, high_s2_q, lock_s1_q, lock_s2_q} <= 6'b000000;
    end else begin
      low_s1_q  <= pump_low_edge_in;
      low_s2_q  <= low_s1_q;
      high_s1_q <= pump_high_edge_in;
      high_s2_q <= high_s1_q;
      lock_s1_q <= loop_lock_in;
      lock_s2_q <= lock_s1_q;
    end
  end

  // Control registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      loop_ctrl_q <= RST_LOOP_CTRL;
      predivide_q <= RST_PREDIVIDE;
      term_cal_q  <= RST_TERM_CAL;
      link_a_q    <= RST_LINK_CTRL_A;
      link_b_q    <= RST_LINK_CTRL_B;
    end else begin
      if (wr_loop)   loop_ctrl_q <= cfg_wdata_in;
      if (wr_prediv) predivide_q <= cfg_wdata_in;
      if (wr_term)   term_cal_q  <= cfg_wdata_in & 8'h01;
      if (wr_link_a) link_a_q    <= cfg_wdata_in & MASK_LINK_CTRL_A;
      if (wr_link_b) link_b_q    <= cfg_wdata_in;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < PACKED_COUNT; gp++) begin : g_packed
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          packed_q[gp] <= RST_PACKED;
        end else if (cfg_wr_in && in_packed && (packed_idx == 4'(gp))) begin
          packed_q[gp] <= cfg_wdata_in;
        end
      end
    end
  endgenerate

  // Loop calibration sequencer
  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    cal_good_d = cal_good_q;
    if (power_off) begin
      state_d    = SEQ_IDLE;
      cnt_d      = '0;
      cal_good_d = 1'b0;
    end else if (seq_start) begin
      state_d    = SEQ_BIAS;
      cnt_d      = '0;
      cal_good_d = 1'b0;
    end else begin
      case (state_q)
        SEQ_IDLE: begin
          cnt_d = '0;
        end
        SEQ_BIAS: begin
          cnt_d = cnt_q + 10'd1;
          if (cnt_q == 10'(BIAS_CYC - 1)) begin
            state_d = SEQ_OSC;
            cnt_d   = '0;
          end
        end
        SEQ_OSC: begin
          cnt_d = cnt_q + 10'd1;
          if (cnt_q == 10'(OSC_CAL_CYC - 1)) begin
            state_d = SEQ_LOCKW;
            cnt_d   = '0;
          end
        end
        SEQ_LOCKW: begin
          cnt_d = cnt_q + 10'd1;
          if (lock_s2_q) begin
            state_d    = SEQ_DONE;
            cal_good_d = !low_s2_q && !high_s2_q;
          end else if (cnt_q == 10'(LOCK_WAIT_CYC - 1)) begin
            state_d = SEQ_DONE;
          end
        end
        SEQ_DONE: begin
          cnt_d = '0;
        end
        default: begin
          state_d = SEQ_IDLE;
          cnt_d   = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q    <= SEQ_IDLE;
      cnt_q      <= '0;
      cal_good_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      cal_good_q <= cal_good_d;
    end
  end

  // Termination calibration; a retrigger while busy restarts it
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      term_cnt_q <= '0;
    end else if (term_rise) begin
      term_cnt_q <= 8'(TERM_CAL_CYC);
    end else if (term_cnt_q != 8'h00) begin
      term_cnt_q <= term_cnt_q - 8'h01;
    end
  end

  // Link parameter checksum per lane; the lane id field is offset by lane index
  function automatic logic [7:0] lane_sum(input logic [7:0] p [PACKED_COUNT], input logic method,
                                          input logic [7:0] lane);
    logic [7:0] lid;
    logic [7:0] acc;
    lid = 8'(p[PACKED_LID_INDEX] + lane);
    acc = 8'h00;
    if (method) begin
      for (int i = 0; i < PACKED_COUNT; i++) begin
        acc = 8'(acc + ((i == PACKED_LID_INDEX) ? lid : p[i]));
      end
    end else begin
      acc = 8'(p[0] + {4'h0, p[1][3:0]} + {3'b000, lid[4:0]} + {7'h00, p[3][7]}
              + {3'b000, p[3][4:0]} + p[4] + {3'b000, p[5][4:0]} + p[6] + {6'h00, p[7][7:6]}
              + {3'b000, p[7][4:0]} + {5'h00, p[8][7:5]} + {3'b000, p[8][4:0]}
              + {5'h00, p[9][7:5]} + {3'b000, p[9][4:0]} + {7'h00, p[10][7]}
              + {3'b000, p[10][4:0]});
    end
    return acc;
  endfunction

  genvar gl;
  generate
    for (gl = 0; gl < LANE_COUNT; gl++) begin : g_lane
      assign sum_d[gl] = lane_sum(packed_q, link_a_q[BIT_SUM_METHOD], 8'(gl));
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          sum_q[gl] <= 8'h00;
        end else begin
          sum_q[gl] <= sum_d[gl];
        end
      end
    end
  endgenerate

  // Read mux; unmapped addresses read zero
  wire [11:0] sum_off  = 12'(cfg_addr_in - ADDR_SUM_LANE0);
  wire        in_sum   = (cfg_addr_in >= ADDR_SUM_LANE0) && (sum_off[2:0] == 3'b000)
                         && (sum_off[11:3] < 9'(LANE_COUNT));
  wire [7:0]  rd_mux   = (cfg_addr_in == ADDR_LOOP_CTRL)   ? loop_ctrl_q :
                         (cfg_addr_in == ADDR_LOOP_STATUS) ? status_w :
                         (cfg_addr_in == ADDR_PREDIVIDE)   ? predivide_q :
                         (cfg_addr_in == ADDR_TERM_CAL)    ? term_cal_q :
                         (cfg_addr_in == ADDR_LINK_CTRL_A) ? link_a_q :
                         (cfg_addr_in == ADDR_LINK_CTRL_B) ? link_b_q :
                         in_packed ? packed_q[packed_idx] :
                         in_sum    ? sum_q[sum_off[4:3]] : 8'h00;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= cfg_rd_in ? rd_mux : rdata_q;
      rvalid_q <= cfg_rd_in;
    end
  end

  assign cfg_rdata_out            = rdata_q;
  assign cfg_rvalid_out           = rvalid_q;
  assign lane_loop_power_on_out   = loop_ctrl_q[BIT_POWER_ON];
  assign oscillator_cal_run_out   = osc_run_w;
  assign refclk_predivide_sel_out = predivide_q[1:0];
  assign term_cal_start_out       = (term_cnt_q == 8'(TERM_CAL_CYC));
  assign term_cal_busy_out        = (term_cnt_q != 8'h00);
  assign link_enable_out          = link_a_q[BIT_LINK_ENABLE];

  // Checks
  property p_low_flag;
    @(posedge clk_in) disable iff (rst_in)
    (cfg_rd_in && cfg_addr_in == ADDR_LOOP_STATUS) |=> (cfg_rdata_out[BIT_PUMP_LOW] == $past(low_s2_q));
  endproperty
  a_low_flag: assert property (p_low_flag) else $error("low edge flag not reported");

  property p_cal_good;
    @(posedge clk_in) disable iff (rst_in)
    $rose(cal_good_q) |-> ($past(state_q) == SEQ_LOCKW) && locked_w;
  endproperty
  a_cal_good: assert property (p_cal_good) else $error("cal good without completed lock");

  property p_osc_start;
    @(posedge clk_in) disable iff (rst_in)
    seq_start |-> ##101 (osc_run_w || !loop_ctrl_q[BIT_POWER_ON] || state_q == SEQ_BIAS);
  endproperty
  a_osc_start: assert property (p_osc_start) else $error("oscillator cal did not start on time");

  property p_bias;
    @(posedge clk_in) disable iff (rst_in)
    $rose(osc_run_w) |-> bias_ok_w && $past(state_q == SEQ_BIAS) && !$past(bias_ok_w);
  endproperty
  a_bias: assert property (p_bias) else $error("bias ready out of order");

  property p_lock;
    @(posedge clk_in) disable iff (rst_in)
    (state_q == SEQ_DONE && lock_s2_q) |-> status_w[BIT_LOCKED] && !status_w[BIT_OSC_RUNNING];
  endproperty
  a_lock: assert property (p_lock) else $error("lock bit not reported");

  property p_prediv;
    @(posedge clk_in) disable iff (rst_in)
    wr_prediv |=> refclk_predivide_sel_out == $past(cfg_wdata_in[1:0]);
  endproperty
  a_prediv: assert property (p_prediv) else $error("pre-divide select not applied");

  property p_term_once;
    @(posedge clk_in) disable iff (rst_in)
    term_rise |=> term_cal_start_out ##1 (!term_cal_start_out && term_cal_busy_out);
  endproperty
  a_term_once: assert property (p_term_once) else $error("termination cal not one start");

  property p_term_level;
    @(posedge clk_in) disable iff (rst_in)
    (wr_term && term_cal_q[BIT_TERM_TRIGGER] && !term_cal_start_out) |=> !term_cal_start_out;
  endproperty
  a_term_level: assert property (p_term_level) else $error("held trigger restarted cal");

  property p_recal;
    @(posedge clk_in) disable iff (rst_in)
    (recal_rise && loop_ctrl_q[BIT_POWER_ON] && !power_off) |=> state_q == SEQ_BIAS && !cal_good_q;
  endproperty
  a_recal: assert property (p_recal) else $error("recal edge ignored");

  property p_status_ro;
    @(posedge clk_in) disable iff (rst_in)
    (cfg_wr_in && cfg_addr_in == ADDR_LOOP_STATUS && state_q == SEQ_DONE) |=> $stable(cal_good_q);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status changed by write");

  property p_sum_method;
    @(posedge clk_in) disable iff (rst_in)
    link_a_q[BIT_SUM_METHOD] |=> sum_q[0] == $past(sum_d[0]);
  endproperty
  a_sum_method: assert property (p_sum_method) else $error("computed sum not stored");

  c_done:  cover property (@(posedge clk_in) disable iff (rst_in) $rose(cal_good_q));
  c_term:  cover property (@(posedge clk_in) disable iff (rst_in) term_rise);
  c_recal: cover property (@(posedge clk_in) disable iff (rst_in) recal_rise && state_q == SEQ_DONE);
  c_link:  cover property (@(posedge clk_in) disable iff (rst_in) $rose(link_enable_out) && locked_w);

endmodule // serdes_pll_link_ctrl_regs

// >>> rtl/lane_pll_regs_pkg.sv
// Constants for the lane PLL, termination and receive-link register bank.
// Assumes byte-wide registers on a 12-bit configuration address.
package lane_pll_regs_pkg;

  localparam logic [11:0] ADDR_LOOP_CTRL      = 12'h280;
  localparam logic [11:0] ADDR_LOOP_STATUS    = 12'h281;
  localparam logic [11:0] ADDR_PREDIVIDE      = 12'h289;
  localparam logic [11:0] ADDR_TERM_CAL       = 12'h2A7;
  localparam logic [11:0] ADDR_LINK_CTRL_A    = 12'h300;
  localparam logic [11:0] ADDR_LINK_CTRL_B    = 12'h301;
  localparam logic [11:0] ADDR_SUM_LANE0      = 12'h40E;
  localparam logic [11:0] ADDR_SUM_STRIDE     = 12'h008;
  localparam logic [11:0] ADDR_PACKED_FIRST   = 12'h450;
  localparam logic [11:0] ADDR_PACKED_LAST    = 12'h45C;
  localparam int          PACKED_COUNT        = 13;
  localparam int          LANE_COUNT          = 4;
  localparam int          PACKED_LID_INDEX    = 2;

  // Field positions
  localparam int BIT_POWER_ON      = 0;
  localparam int BIT_RECAL         = 2;
  localparam int BIT_LOCKED        = 0;
  localparam int BIT_BIAS_OK       = 1;
  localparam int BIT_OSC_RUNNING   = 2;
  localparam int BIT_CAL_GOOD      = 3;
  localparam int BIT_PUMP_LOW      = 4;
  localparam int BIT_PUMP_HIGH     = 5;
  localparam int BIT_TERM_TRIGGER  = 0;
  localparam int BIT_LINK_ENABLE   = 0;
  localparam int BIT_SUM_METHOD    = 6;

  // Values after reset, and the link control A write mask
  localparam logic [7:0] RST_LOOP_CTRL   = 8'h00;
  localparam logic [7:0] RST_PREDIVIDE   = 8'hFC;
  localparam logic [7:0] RST_TERM_CAL    = 8'h00;
  localparam logic [7:0] RST_LINK_CTRL_A = 8'h00;
  localparam logic [7:0] RST_LINK_CTRL_B = 8'h01;
  localparam logic [7:0] RST_PACKED      = 8'h00;
  localparam logic [7:0] MASK_LINK_CTRL_A = 8'h41;

  localparam logic [1:0] PREDIV_BY_TWO   = 2'b01;
  localparam logic [1:0] PREDIV_BY_ONE   = 2'b10;

  // Sequencer and termination calibration timing
  localparam int CLK_MHZ       = 50;
  localparam int BIAS_WAIT_NS  = 2000;
  localparam int OSC_CAL_NS    = 10000;
  localparam int LOCK_WAIT_NS  = 20000;
  localparam int TERM_CAL_NS   = 4000;
  localparam int BIAS_CYC      = (BIAS_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int OSC_CAL_CYC   = (OSC_CAL_NS * CLK_MHZ + 999) / 1000;
  localparam int LOCK_WAIT_CYC = (LOCK_WAIT_NS * CLK_MHZ) / 1000;
  localparam int TERM_CAL_CYC  = (TERM_CAL_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b000,
    SEQ_BIAS  = 3'b001,
    SEQ_OSC   = 3'b011,
    SEQ_LOCKW = 3'b010,
    SEQ_DONE  = 3'b110
  } seq_state_e;

endpackage

// >>> tb/serdes_pll_link_ctrl_regs_tb_top.sv
// Self-checking bench for the lane PLL, termination and link register bank.
// Assumes the hand-over timings of the sequencer and the byte register port.
`timescale 1ns/100ps
module serdes_pll_link_ctrl_regs_tb_top
  import lane_pll_regs_pkg::*;
;
  localparam int LIMIT = 6000;
  logic        clk_in;
  logic        rst_in;
  logic [11:0] cfg_addr_in;
  logic [7:0]  cfg_wdata_in;
  logic        cfg_wr_in;
  logic        cfg_rd_in;
  logic        pump_low_edge_in;
  logic        pump_high_edge_in;
  logic        loop_lock_in;
  logic [7:0]  cfg_rdata_out;
  logic        cfg_rvalid_out;
  logic        lane_loop_power_on_out;
  logic        oscillator_cal_run_out;
  logic [1:0]  refclk_predivide_sel_out;
  logic        term_cal_start_out;
  logic        term_cal_busy_out;
  logic        link_enable_out;
  int          fails;
  int          tests_run;
  int          cycles;
  int          cfg_model[$];
  int          sum;
  int          n;
  int          m;
  logic        seen;

  serdes_pll_link_ctrl_regs DUT (
    .clk_in                   (clk_in),
    .rst_in                   (rst_in),
    .cfg_addr_in              (cfg_addr_in),
    .cfg_wdata_in             (cfg_wdata_in),
    .cfg_wr_in                (cfg_wr_in),
    .cfg_rd_in                (cfg_rd_in),
    .pump_low_edge_in         (pump_low_edge_in),
    .pump_high_edge_in        (pump_high_edge_in),
    .loop_lock_in             (loop_lock_in),
    .cfg_rdata_out            (cfg_rdata_out),
    .cfg_rvalid_out           (cfg_rvalid_out),
    .lane_loop_power_on_out   (lane_loop_power_on_out),
    .oscillator_cal_run_out   (oscillator_cal_run_out),
    .refclk_predivide_sel_out (refclk_predivide_sel_out),
    .term_cal_start_out       (term_cal_start_out),
    .term_cal_busy_out        (term_cal_busy_out),
    .link_enable_out          (link_enable_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic print_verdict();
    $display("Counts: %0d compared, %0d mismatched", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard: full run needs well under half of this
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails = fails + 1;
      print_verdict();
    end
  end

  task automatic tick();
    @(posedge clk_in);
    #2;
  endtask

  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      fails = fails + 1;
    end
  endtask

  task automatic chk_int(input string name, input int exp, input int got);
    tests_run = tests_run + 1;
    if (got != exp) begin
      $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
      fails = fails + 1;
    end
  endtask

  // Strobe stays low for one edge, so a following call never re-raises it in the same step
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    cfg_addr_in  = a;
    cfg_wdata_in = d;
    cfg_wr_in    = 1'b1;
    tick();
    cfg_wr_in    = 1'b0;
    tick();
  endtask

  // Read taken at the first edge; rvalid and data stand right after it
  task automatic rdchk(input string name, input logic [11:0] a, input logic [7:0] exp);
    cfg_addr_in = a;
    cfg_rd_in   = 1'b1;
    tick();
    chk8({name, " rvalid"}, 8'h01, {7'h00, cfg_rvalid_out});
    chk8(name, exp, cfg_rdata_out);
    cfg_rd_in   = 1'b0;
    tick();
  endtask

  // Edges counted from the write edge; write and status read use three of them
  task automatic osc_cycle(input logic [7:0] ctrl, input logic [7:0] base);
    wr(ADDR_LOOP_CTRL, ctrl);
    rdchk("status bias", ADDR_LOOP_STATUS, base);
    n = 3;
    while (oscillator_cal_run_out !== 1'b1 && n < 200) begin
      tick();
      n = n + 1;
    end
    chk_int("osc start", BIAS_CYC, n);
    rdchk("status osc", ADDR_LOOP_STATUS, base | 8'h06);
    m = 2;
    while (oscillator_cal_run_out !== 1'b0 && m < 700) begin
      tick();
      m = m + 1;
    end
    chk_int("osc length", OSC_CAL_CYC, m);
  endtask

  initial begin
    cycles = 0;
    fails = 0;
    tests_run = 0;
    rst_in = 1'b1;
    cfg_addr_in = 12'h000;
    cfg_wdata_in = 8'h00;
    cfg_wr_in = 1'b0;
    cfg_rd_in = 1'b0;
    pump_low_edge_in = 1'b0;
    pump_high_edge_in = 1'b0;
    loop_lock_in = 1'b0;
    void'($urandom(43));
    tick();
    tick();
    rst_in = 1'b0;

    rdchk("predivide rst", ADDR_PREDIVIDE, 8'hFC);
    rdchk("link b rst", ADDR_LINK_CTRL_B, 8'h01);
    rdchk("link a rst", ADDR_LINK_CTRL_A, 8'h00);
    chk8("predivide sel rst", 8'h00, {6'h00, refclk_predivide_sel_out});
    // Codes chosen for a reference that lands inside the detector band
    wr(ADDR_PREDIVIDE, {6'h3F, PREDIV_BY_TWO});
    chk8("predivide sel", 8'h01, {6'h00, refclk_predivide_sel_out});
    wr(ADDR_PREDIVIDE, {6'h3F, PREDIV_BY_ONE});
    chk8("predivide sel", 8'h02, {6'h00, refclk_predivide_sel_out});
    rdchk("predivide", ADDR_PREDIVIDE, 8'hFE);
    n = $urandom() & 8'hFF;
    wr(ADDR_LINK_CTRL_B, n[7:0]);
    rdchk("link b", ADDR_LINK_CTRL_B, n[7:0]);
    wr(12'h7FF, n[7:0]);
    rdchk("unmapped", 12'h7FF, 8'h00);
    $display("Test registers done");

    loop_lock_in = 1'b1;
    osc_cycle(8'h01, 8'h00);
    chk8("power on", 8'h01, {7'h00, lane_loop_power_on_out});
    repeat (4) tick();
    rdchk("status locked", ADDR_LOOP_STATUS, 8'h0B);
    pump_low_edge_in = 1'b1;
    repeat (4) tick();
    rdchk("status pump", ADDR_LOOP_STATUS, 8'h1B);
    wr(ADDR_LOOP_STATUS, 8'h00);
    rdchk("status kept", ADDR_LOOP_STATUS, 8'h1B);
    // Recal with the pump flag up: calibration may not be reported good
    osc_cycle(8'h05, 8'h10);
    repeat (4) tick();
    rdchk("status recal", ADDR_LOOP_STATUS, 8'h13);
    wr(ADDR_LOOP_CTRL, 8'h05);
    seen = 1'b0;
    repeat (120) begin
      tick();
      seen = seen | oscillator_cal_run_out;
    end
    chk8("no restart", 8'h00, {7'h00, seen});
    pump_low_edge_in = 1'b0;
    $display("Test sequencer done");

    // Inline write: the start pulse stands only until the next edge
    cfg_addr_in  = ADDR_TERM_CAL;
    cfg_wdata_in = 8'hFF;
    cfg_wr_in    = 1'b1;
    tick();
    cfg_wr_in    = 1'b0;
    chk8("term start", 8'h01, {7'h00, term_cal_start_out});
    m = 0;
    while (term_cal_busy_out !== 1'b0 && m < 300) begin
      tick();
      m = m + 1;
    end
    chk_int("term busy", TERM_CAL_CYC, m);
    rdchk("term reg", ADDR_TERM_CAL, 8'h01);
    wr(ADDR_TERM_CAL, 8'h01);
    seen = 1'b0;
    repeat (10) begin
      tick();
      seen = seen | term_cal_start_out | term_cal_busy_out;
    end
    chk8("term no restart", 8'h00, {7'h00, seen});
    $display("Test termination done");

    sum = 0;
    for (int i = 0; i < PACKED_COUNT; i++) begin
      cfg_model.push_back($urandom() & 8'hFF);
      wr(ADDR_PACKED_FIRST + 12'(i), 8'(cfg_model[i]));
      sum = (sum + cfg_model[i]) % 256;
    end
    // Link enable written once status reads locked with no oscillator calibration; link_enable_out is not gated by lock
    rdchk("status before link", ADDR_LOOP_STATUS, 8'h03);
    wr(ADDR_LINK_CTRL_A, 8'hC1);
    chk8("link enable", 8'h01, {7'h00, link_enable_out});
    rdchk("link a", ADDR_LINK_CTRL_A, 8'h41);
    rdchk("lane0 sum", ADDR_SUM_LANE0, 8'(sum));
    rdchk("lane1 sum", ADDR_SUM_LANE0 + ADDR_SUM_STRIDE, 8'(sum + 1));
    wr(ADDR_SUM_LANE0, 8'(sum + 1));
    rdchk("lane0 sum kept", ADDR_SUM_LANE0, 8'(sum));
    // Field sum over the standard link configuration table packing
    sum = cfg_model[0] + (cfg_model[1] & 15) + (cfg_model[2] & 31) + (cfg_model[3] >> 7)
          + (cfg_model[3] & 31) + cfg_model[4] + (cfg_model[5] & 31) + cfg_model[6]
          + (cfg_model[7] >> 6) + (cfg_model[7] & 31) + (cfg_model[8] >> 5) + (cfg_model[8] & 31)
          + (cfg_model[9] >> 5) + (cfg_model[9] & 31) + (cfg_model[10] >> 7) + (cfg_model[10] & 31);
    wr(ADDR_LINK_CTRL_A, 8'h01);
    rdchk("lane0 field sum", ADDR_SUM_LANE0, 8'(sum));
    $display("Test checksum done");
    print_verdict();
  end
endmodule // serdes_pll_link_ctrl_regs_tb_top
